//--- hdl/scsc_pkg.sv
package scsc_pkg;

  // ****************************************
  // Word and address layout
  // ****************************************
  localparam int DATA_W      = 24;
  localparam int GRP_W       = 6;
  localparam int NGRP        = 4;
  localparam int WORD_W      = DATA_W + NGRP;
  localparam int ADDR_W      = 13;
  localparam int FIELD_BIT   = 12;
  localparam int FIELD_WORDS = 4096;
  localparam int FIELDS      = 2;
  localparam int ADDR15_W    = 15;
  localparam int ADDR17_W    = 17;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS    = 25;
  localparam int CYCLE_NS  = 1750;
  localparam int ACCESS_NS = 1000;
  localparam int CYC_CLKS  = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CLKS  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 7;
  localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACC_CLKS - 1);
  localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYC_CLKS - 1);

  // ****************************************
  // APB register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] STAT_OFS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_OFS = 8'h08;
  localparam logic [APB_AW-1:0] DATA_OFS = 8'h0C;

  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_DEFEAT  = 2;
  localparam int CTRL_CLEAR   = 3;
  localparam int STAT_HALT    = 0;
  localparam int STAT_FAULT   = 1;
  localparam int STAT_LAMP    = 2;
  localparam int STAT_BUSY    = 3;
  localparam int STAT_OWNER   = 4;
  localparam int STAT_LAST    = 5;

  // Selector positions
  localparam logic [1:0] SEL_LEFT   = 2'h0;
  localparam logic [1:0] SEL_SHARED = 2'h1;
  localparam logic [1:0] SEL_RIGHT  = 2'h2;
  localparam logic [1:0] SEL_RST    = SEL_SHARED;
  localparam logic       DEFEAT_RST = 1'h0;

  // Read/modify modes
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_CHAR1,
    MODE_CHAR2,
    MODE_CHAR3,
    MODE_FULL,
    MODE_ADDR15,
    MODE_ADDR17
  } scsc_mode_t;

endpackage

//--- hdl/scsc_store_mem.sv
`timescale 1ns/1ps

module scsc_store_mem #(
  parameter int AW = 13,
  parameter int DW = 28
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  // ****************************************
  // Core array, registered read
  // ****************************************
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule

//--- hdl/scsc_store_ctrl.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Stored word is 28 bits, 24 data
// - Four 6-bit groups, one parity each
// - Every write generates four parity bits
// - Parity is odd per group
// - Read parity travels with data, checked
// - Parity mismatch raises fault, halts at once
// - Defeat switch suppresses the halt
// - Panel lamp lights on parity error
// - Outer selector positions give exclusive use
// - Middle position scans both, no priority
// - Served processor yields after its cycle
// - 13-bit address, bit 12 picks field
// - 28-bit data register holds restored word
// - Fields of 4096 words form one store
// - Normal cycle reads, writes word back
// - Modify modes suppress portion, load new
// - Data register cleared after write unless halted
module scsc_store_ctrl #(
  parameter int FIELDS = scsc_pkg::FIELDS
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [scsc_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Storage requests, index 0 left, 1 right
  input  wire logic [1:0]                  rq_valid,
  input  wire logic [1:0][12:0]            rq_addr,
  input  wire logic [1:0][2:0]             rq_mode,
  input  wire logic [1:0][1:0]             rq_pos,
  input  wire logic [1:0][23:0]            rq_wdata,
  // Storage answers
  output logic      [1:0]                  rq_grant,
  output logic      [1:0]                  rq_done,
  output logic      [23:0]                 rd_data,
  output logic      [3:0]                  rd_par,
  // Panel and processor halt
  output logic                             halt,
  output logic                             mem_fault,
  output logic                             parity_lamp
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } scsc_st_t;

  typedef struct packed {
    scsc_st_t                       st;
    logic [scsc_pkg::CNT_W-1:0]     cnt;
    logic                           owner;
    logic                           last;
    logic [scsc_pkg::ADDR_W-1:0]    s_reg;
    logic [scsc_pkg::WORD_W-1:0]    z_reg;
    logic [scsc_pkg::DATA_W-1:0]    inh;
    logic [scsc_pkg::DATA_W-1:0]    new_data;
    logic [1:0]                     sel;
    logic                           defeat;
    logic                           halt;
    logic                           fault;
    logic                           lamp;
    logic [1:0]                     grant;
    logic [1:0]                     done;
    logic [scsc_pkg::DATA_W-1:0]    rd_data;
    logic [scsc_pkg::NGRP-1:0]      rd_par;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
  } scsc_state_t;

  scsc_state_t s_q;
  scsc_state_t s_d;

  logic                        mem_we;
  logic [scsc_pkg::WORD_W-1:0] mem_wdata;
  logic [scsc_pkg::WORD_W-1:0] mem_rdata;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] gen_par(input logic [23:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < scsc_pkg::NGRP; i++) begin
      p[i] = ~^d[i*scsc_pkg::GRP_W +: scsc_pkg::GRP_W];
    end
    return p;
  endfunction

  // Inhibit mask of the portion to be replaced
  function automatic logic [23:0] inh_mask(input logic [2:0] mode,
                                           input logic [1:0] pos);
    logic [3:0]  g;
    logic [23:0] m;
    g = 4'h0;
    m = 24'h000000;
    unique case (scsc_pkg::scsc_mode_t'(mode))
      scsc_pkg::MODE_CHAR1:  g = 4'h1 << pos;
      scsc_pkg::MODE_CHAR2: begin
        unique case (pos)
          2'h0:    g = 4'hC;
          2'h1:    g = 4'h6;
          default: g = 4'h3;
        endcase
      end
      scsc_pkg::MODE_CHAR3:  g = pos[0] ? 4'h7 : 4'hE;
      scsc_pkg::MODE_FULL:   g = 4'hF;
      default:               g = 4'h0;
    endcase
    for (int i = 0; i < scsc_pkg::NGRP; i++) begin
      m[i*scsc_pkg::GRP_W +: scsc_pkg::GRP_W] = {scsc_pkg::GRP_W{g[i]}};
    end
    if (mode == 3'(scsc_pkg::MODE_ADDR15)) begin
      m = 24'((32'h1 << scsc_pkg::ADDR15_W) - 32'h1);
    end
    if (mode == 3'(scsc_pkg::MODE_ADDR17)) begin
      m = 24'((32'h1 << scsc_pkg::ADDR17_W) - 32'h1);
    end
    return m;
  endfunction

  // ****************************************
  // Core store, fields share one array
  // ****************************************
  // Depth is FIELDS * 4096; address bit 12 picks the field
  scsc_store_mem #(
    .AW ($clog2(FIELDS * scsc_pkg::FIELD_WORDS)),
    .DW (scsc_pkg::WORD_W)
  ) u_mem (
    .clk     (pclk),
    .we      (mem_we),
    .addr    (s_q.s_reg[$clog2(FIELDS * scsc_pkg::FIELD_WORDS)-1:0]),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // Restore word with fresh parity on every write
  always_comb begin
    mem_we    = (s_q.st == ST_WRITE) && (s_q.cnt == scsc_pkg::CYC_LAST);
    mem_wdata = {gen_par(s_q.z_reg[scsc_pkg::DATA_W-1:0]),
                 s_q.z_reg[scsc_pkg::DATA_W-1:0]};
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0]                  elig;
    logic                        pick;
    logic [scsc_pkg::DATA_W-1:0] rdw;
    logic [scsc_pkg::DATA_W-1:0] merged;
    logic [scsc_pkg::NGRP-1:0]   chk;
    logic [scsc_pkg::NGRP-1:0]   bad;
    logic                        perr;
    logic                        access;
    logic                        wr_ctrl;

    elig        = 2'h0;
    pick        = 1'b0;
    rdw         = 24'h000000;
    merged      = 24'h000000;
    chk         = 4'h0;
    bad         = 4'h0;
    perr        = 1'b0;
    s_d         = s_q;
    s_d.grant   = 2'h0;
    s_d.done    = 2'h0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // Answer one cycle late so read data come from a flop
    access      = psel && penable && !s_q.pready;
    wr_ctrl     = psel && penable && s_q.pready && pwrite &&
                  (paddr == scsc_pkg::CTRL_OFS);

    // ****************************************
    // Selector and scanner
    // ****************************************
    // Selector gating; lockout leaves requests pending
    unique case (s_q.sel)
      scsc_pkg::SEL_LEFT:  elig = rq_valid & 2'h1;
      scsc_pkg::SEL_RIGHT: elig = rq_valid & 2'h2;
      default:             elig = rq_valid;
    endcase
    // Alternate when both wait, so neither waits past one cycle
    pick = (elig == 2'h3) ? ~s_q.last : elig[1];

    // ****************************************
    // Read path and parity check
    // ****************************************
    rdw    = mem_rdata[scsc_pkg::DATA_W-1:0] & ~s_q.inh;
    merged = rdw | (s_q.new_data & s_q.inh);
    // Only groups read in full are checked
    for (int i = 0; i < scsc_pkg::NGRP; i++) begin
      chk[i] = ~|s_q.inh[i*scsc_pkg::GRP_W +: scsc_pkg::GRP_W];
    end
    bad  = gen_par(mem_rdata[scsc_pkg::DATA_W-1:0]) ^
           mem_rdata[scsc_pkg::WORD_W-1:scsc_pkg::DATA_W];
    perr = |(bad & chk);

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    if (access) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      unique case (paddr)
        scsc_pkg::CTRL_OFS: begin
          s_d.prdata[scsc_pkg::CTRL_SEL_LSB +: 2] = s_q.sel;
          s_d.prdata[scsc_pkg::CTRL_DEFEAT]       = s_q.defeat;
        end
        scsc_pkg::STAT_OFS: begin
          s_d.prdata[scsc_pkg::STAT_HALT]  = s_q.halt;
          s_d.prdata[scsc_pkg::STAT_FAULT] = s_q.fault;
          s_d.prdata[scsc_pkg::STAT_LAMP]  = s_q.lamp;
          s_d.prdata[scsc_pkg::STAT_BUSY]  = (s_q.st != ST_IDLE);
          s_d.prdata[scsc_pkg::STAT_OWNER] = s_q.owner;
          s_d.prdata[scsc_pkg::STAT_LAST]  = s_q.last;
        end
        scsc_pkg::ADDR_OFS: begin
          s_d.prdata[scsc_pkg::ADDR_W-1:0] = s_q.s_reg;
        end
        scsc_pkg::DATA_OFS: begin
          s_d.prdata[scsc_pkg::WORD_W-1:0] = s_q.z_reg;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // Writes act on the edge that completes the transfer
    if (wr_ctrl) begin
      s_d.sel    = pwdata[scsc_pkg::CTRL_SEL_LSB +: 2];
      s_d.defeat = pwdata[scsc_pkg::CTRL_DEFEAT];
      if (pwdata[scsc_pkg::CTRL_CLEAR]) begin
        s_d.halt  = 1'b0;
        s_d.fault = 1'b0;
        s_d.lamp  = 1'b0;
      end
    end

    // ****************************************
    // Storage cycle
    // ****************************************
    unique case (s_q.st)
      ST_IDLE: begin
        // A halted machine issues no new cycles
        if (!s_q.halt && (elig != 2'h0)) begin
          s_d.st          = ST_READ;
          s_d.cnt         = '0;
          s_d.owner       = pick;
          s_d.last        = pick;
          s_d.grant[pick] = 1'b1;
          s_d.s_reg       = rq_addr[pick];
          s_d.inh         = inh_mask(rq_mode[pick], rq_pos[pick]);
          s_d.new_data    = rq_wdata[pick];
        end
      end
      ST_READ: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == scsc_pkg::ACC_LAST) begin
          s_d.st               = ST_WRITE;
          s_d.z_reg            = {gen_par(merged), merged};
          s_d.done[s_q.owner]  = 1'b1;
          s_d.rd_data          = rdw;
          s_d.rd_par           =
            mem_rdata[scsc_pkg::WORD_W-1:scsc_pkg::DATA_W];
          // Set after the clear so a same-edge error wins
          if (perr) begin
            s_d.fault = 1'b1;
            s_d.lamp  = 1'b1;
            if (!s_q.defeat) begin
              s_d.halt = 1'b1;
            end
          end
        end
      end
      ST_WRITE: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == scsc_pkg::CYC_LAST) begin
          s_d.st  = ST_IDLE;
          s_d.cnt = '0;
          // Keep the failing word visible while halted
          if (!s_q.halt) begin
            s_d.z_reg = '0;
          end
        end
      end
      default: begin
        s_d.st  = ST_IDLE;
        s_d.cnt = '0;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      // Panel switches wake in their default positions
      s_q.sel    <= scsc_pkg::SEL_RST;
      s_q.defeat <= scsc_pkg::DEFEAT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign rq_grant    = s_q.grant;
  assign rq_done     = s_q.done;
  assign rd_data     = s_q.rd_data;
  assign rd_par      = s_q.rd_par;
  assign halt        = s_q.halt;
  assign mem_fault   = s_q.fault;
  assign parity_lamp = s_q.lamp;

endmodule

//--- tb/scsc_store_ctrl_chk.sv
`timescale 1ns/1ps

module scsc_store_ctrl_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Store and panel
  input wire logic [1:0]  rq_valid,
  input wire logic [1:0]  rq_grant,
  input wire logic [1:0]  rq_done,
  input wire logic        halt,
  input wire logic        mem_fault,
  input wire logic        parity_lamp
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************
  // Switch shadow
  // ****************
  logic       wr;
  logic [1:0] sel_q;
  logic       def_q;

  assign wr = psel && penable && pready && pwrite
           && paddr == scsc_pkg::CTRL_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= scsc_pkg::SEL_RST;
      def_q <= scsc_pkg::DEFEAT_RST;
    end else if (wr) begin
      sel_q <= pwdata[1:0];
      def_q <= pwdata[scsc_pkg::CTRL_DEFEAT];
    end
  end

  // ****************
  // Properties
  // ****************
  a_grant_alone:
    assert property ($onehot0(rq_grant))
    else $error("both processors granted");
  a_grant_cause:
    assert property ((rq_grant & ~$past(rq_valid)) == 2'h0)
    else $error("grant without request");
  a_done_delay:
    assert property (rq_grant != 2'h0 |-> ##40 rq_done == $past(rq_grant, 40))
    else $error("done not 40 cycles after grant");
  a_cycle_gap:
    assert property (rq_grant != 2'h0 |=> (rq_grant == 2'h0) [*8])
    else $error("grant inside running cycle");
  a_lock_right:
    assert property (rq_grant[1] |-> $past(sel_q) != scsc_pkg::SEL_LEFT)
    else $error("right granted while locked out");
  a_lock_left:
    assert property (rq_grant[0] |-> $past(sel_q) != scsc_pkg::SEL_RIGHT)
    else $error("left granted while locked out");
  a_halt_stop:
    assert property ($past(halt) |-> rq_grant == 2'h0)
    else $error("grant while halted");
  a_halt_fault:
    assert property (halt |-> mem_fault)
    else $error("halt without fault");
  a_defeat_hold:
    assert property ($rose(halt) |-> !$past(def_q))
    else $error("halt despite defeat switch");
  a_lamp_fault:
    assert property ($rose(mem_fault) |-> parity_lamp)
    else $error("fault without lamp");
  a_fault_stay:
    assert property (mem_fault && !(wr && pwdata[3]) |=> mem_fault)
    else $error("fault dropped without clear");

  c_both: cover property (rq_grant[0] ##[1:100] rq_grant[1]);
  c_right: cover property (rq_done[1]);
  c_write: cover property (wr);
endmodule

bind scsc_store_ctrl scsc_store_ctrl_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .rq_valid, .rq_grant, .rq_done, .halt, .mem_fault, .parity_lamp
);

//--- tb/scsc_proc_model.sv
`timescale 1ns/1ps

module scsc_proc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench and store
  input wire logic want,
  input wire logic done,
  output logic     req_q
);
  // ****************
  // Request hold
  // ****************
  // Main and block control merged; the scan gap is one idle cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      req_q <= 1'b0;
    else if (req_q && done)
      req_q <= 1'b0;
    else if (want)
      req_q <= 1'b1;
  end
endmodule

//--- tb/test_shared_core_store_control.sv
`timescale 1ns/1ps

module test_shared_core_store_control;
  // ****************
  // Signals
  // ****************
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  wire  [1:0]       rq_valid;
  logic [1:0][12:0] rq_addr;
  logic [1:0][2:0]  rq_mode;
  logic [1:0][1:0]  rq_pos;
  logic [1:0][23:0] rq_wdata;
  logic [1:0]       rq_grant;
  logic [1:0]       rq_done;
  logic [23:0]      rd_data;
  logic [3:0]       rd_par;
  logic             halt;
  logic             mem_fault;
  logic             parity_lamp;
  logic [1:0]       want;
  logic             slv;
  logic [23:0]      rdat;
  logic [3:0]       rpar;
  int               mismatches = 0;
  int               num_checks = 0;
  int               cyc = 0;

  scsc_store_ctrl dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rq_valid, .rq_addr, .rq_mode, .rq_pos, .rq_wdata,
    .rq_grant, .rq_done, .rd_data, .rd_par, .halt, .mem_fault,
    .parity_lamp
  );

  for (genvar i = 0; i < 2; i++) begin : g_proc
    scsc_proc_model u_proc (
      .pclk, .presetn, .want(want[i]), .done(rq_done[i]),
      .req_q(rq_valid[i])
    );
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [3:0] opar(input logic [23:0] d);
    for (int g = 0; g < 4; g++) opar[g] = ~^d[6*g+:6];
  endfunction

  // Portion replaced by each modify mode
  function automatic logic [23:0] msk(input logic [2:0] m,
                                      input logic [1:0] p);
    case (m)
      3'h1: msk = 24'h00003F << (6 * p);
      3'h2: msk = 24'hFFF000 >> (6 * p);
      3'h3: msk = 24'hFFFFC0 >> (6 * p);
      3'h4: msk = 24'hFFFFFF;
      3'h5: msk = 24'h007FFF;
      3'h6: msk = 24'h01FFFF;
      default: msk = 24'h000000;
    endcase
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One storage cycle; request held until done
  task automatic acc(input int i, input logic [12:0] a, input logic [2:0] m,
                     input logic [1:0] p, input logic [23:0] d);
    int n;
    n = 0;
    rq_addr[i] <= a;
    rq_mode[i] <= m;
    rq_pos[i] <= p;
    rq_wdata[i] <= d;
    want[i] <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rq_done[i] !== 1'b1 && n < 300);
    if (n >= 300) mismatches++;
    rdat = rd_data;
    rpar = rd_par;
    want[i] <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Run takes about 2300 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 6000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    logic [31:0] r;
    logic [23:0] w;
    logic [23:0] mk;
    logic [1:0]  sels [3];
    int          g [2];
    int          rep;
    int          cur;
    int          prev;
    int          lk;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rq_addr = '0;
    rq_mode = '0;
    rq_pos = '0;
    rq_wdata = '0;
    want = 2'h0;
    sels = '{scsc_pkg::SEL_RIGHT, scsc_pkg::SEL_LEFT, scsc_pkg::SEL_SHARED};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, scsc_pkg::CTRL_OFS, 32'h0, r);
    chk(r, 32'h1);
    apb(1'b0, scsc_pkg::STAT_OFS, 32'h0, r);
    chk(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r);
    chk({31'h0, slv}, 32'h1);
    apb(1'b1, scsc_pkg::CTRL_OFS, 32'hD, r);
    apb(1'b0, scsc_pkg::CTRL_OFS, 32'h0, r);
    chk(r, 32'h5);
    apb(1'b1, scsc_pkg::CTRL_OFS, 32'h1, r);
    acc(0, 13'h0005, 3'h4, 2'h0, 24'h5A5A5A);
    acc(0, 13'h1005, 3'h4, 2'h0, 24'hA5C3F0);
    chk({8'h0, rdat}, 32'h0);
    acc(1, 13'h0005, 3'h0, 2'h0, 24'h0);
    chk({8'h0, rdat}, 32'h5A5A5A);
    acc(1, 13'h1005, 3'h0, 2'h0, 24'h0);
    chk({8'h0, rdat}, 32'hA5C3F0);
    chk({28'h0, rpar}, {28'h0, opar(24'hA5C3F0)});
    apb(1'b0, scsc_pkg::ADDR_OFS, 32'h0, r);
    chk(r, 32'h1005);
    repeat (32) @(posedge pclk);
    apb(1'b0, scsc_pkg::DATA_OFS, 32'h0, r);
    chk(r, 32'h0);
    w = 24'hA5C3F0;
    for (int m = 1; m < 8; m++) begin
      mk = msk(3'(m), 2'(m % 3));
      acc(m % 2, 13'h1005, 3'(m), 2'(m % 3), 24'h3C96E1);
      chk({8'h0, rdat}, {8'h0, w & ~mk});
      w = (w & ~mk) | (24'h3C96E1 & mk);
      acc(0, 13'h1005, 3'h0, 2'h0, 24'h0);
      chk({8'h0, rdat}, {8'h0, w});
      chk({28'h0, rpar}, {28'h0, opar(w)});
    end
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, scsc_pkg::CTRL_OFS, {30'h0, sels[k]}, r);
      want <= 2'h3;
      g[0] = 0;
      g[1] = 0;
      rep = 0;
      prev = 2;
      repeat (2) @(posedge pclk);
      repeat (300) begin
        @(posedge pclk);
        if (rq_grant != 2'h0) begin
          cur = int'(rq_grant[1]);
          g[cur]++;
          if (cur == prev) rep++;
          prev = cur;
        end
      end
      lk = k;
      if (k < 2) begin
        chk(32'(g[lk]), 32'h0);
        chk(32'(g[1 - lk] >= 2), 32'h1);
      end else begin
        chk(32'(rep), 32'h0);
        chk(32'(g[0] >= 2 && g[1] >= 2), 32'h1);
      end
    end
    want <= 2'h0;
    repeat (100) @(posedge pclk);
    chk({29'h0, halt, mem_fault, parity_lamp}, 32'h0);
    stop_test();
  end
endmodule
